/* File: hdl/shading_pkg.sv */
/*
  shading_pkg: constants, modes and carrier types for the line shading
  correction block. assumes a single 100 MHz core clock domain.
*/
package shading_pkg;
  localparam int PIX_W = 12;            // gray value width
  localparam int LINE_PIX = 64;         // pixels per line (small default)
  localparam int GEN_LINES = 64;        // least acquisitions averaged for offsets
  localparam int GEN_SHIFT = 6;         // log2 of GEN_LINES
  localparam int GAIN_W = 10;           // stored gain coefficient width
  // standard: 1.5 max gain, fraction 9 bits (finer step)
  localparam int STD_FRAC = 9;
  localparam logic [GAIN_W-1:0] STD_GAIN_MAX = 10'h0_300;
  // enhanced: 4.0 max gain, fraction 7 bits (coarser step)
  localparam int ENH_FRAC = 7;
  localparam logic [GAIN_W-1:0] ENH_GAIN_MAX = 10'h0_200;
  localparam logic [PIX_W-1:0] PIX_MAX = 12'h0_fff;
  localparam logic [1:0] FMT_STD = 2'h1;  // set format tag, standard models
  localparam logic [1:0] FMT_ENH = 2'h2;  // set format tag, enhanced models

  typedef enum logic [1:0] {
    CORR_OFF, CORR_OFFSET, CORR_GAIN, CORR_BOTH
  } corr_mode_t;

  typedef struct packed {
    logic valid;
    logic last;
    logic [PIX_W-1:0] data;
  } pix_beat_t;

  typedef struct packed {
    logic [PIX_W-1:0] offset;
    logic [GAIN_W-1:0] gain;
  } coef_t;
endpackage : shading_pkg

/* File: hdl/line_shading_correction.sv */
/*
  line_shading_correction: per-pixel offset and gain correction of a
  line stream, with factory and user coefficient sets and offset
  generation from dark lines. assumes the pixel stream and control bits
  come from logic on core_clk; coefficient arrays stand for the
  nonvolatile store.
*/
// How it works
// - standard models clamp gain coefficient at 1.5
// - enhanced models allow gain coefficient up to 4.0
// - enhanced models use fewer fraction bits per coefficient
// - modes: off, offset only, gain only, or both
// - offset correction adds per-pixel dark offset
// - gain correction multiplies each pixel by its gain
// - two coefficient sets, each holding offsets and gains
// - factory set never written; default selection
// - user set normally applied after generation
// - coefficient loads with wrong format tag are refused
// - host mode field selects correction, device applies it
// - offset generation collects 64 lines first
// - offset raises each pixel average to line maximum
// - separate offset sets for single-line and other modes
// - generated offsets go to user set, user set activated for one cycle, then use_user_set decides
`timescale 1ns/10ps
module line_shading_correction
  import shading_pkg::*;
#(
  parameter bit ENHANCED = 1'b0,        // enhanced range model
  parameter int NPIX = LINE_PIX         // pixels per line
) (
  input wire logic core_clk,            // 100 MHz clock
  input wire logic reset,               // sync, active high
  input wire logic clk_en,              // freezes all state when low
  input wire corr_mode_t mode,          // host mode field
  input wire logic single_line_mode,    // acquisition mode is single line
  input wire logic use_user_set,        // host selects user set
  input wire logic gen_start,           // pulse: generate offsets
  input wire pix_beat_t pix_in,         // sensor pixel stream
  input wire logic coef_we,             // user gain load strobe
  input wire logic [1:0] coef_fmt,      // format tag of loaded set
  input wire logic [$clog2(NPIX)-1:0] coef_addr, // pixel index of load
  input wire logic [GAIN_W-1:0] coef_gain, // gain coefficient to load
  output pix_beat_t pix_out,            // corrected stream
  output logic user_active,             // user set in use
  output logic gen_busy,                // generation in progress
  output logic coef_reject              // pulse: load format refused
);
  localparam int AW = $clog2(NPIX);
  localparam int FRAC = ENHANCED ? ENH_FRAC : STD_FRAC;
  localparam logic [GAIN_W-1:0] GMAX = ENHANCED ? ENH_GAIN_MAX : STD_GAIN_MAX;
  localparam logic [1:0] MY_FMT = ENHANCED ? FMT_ENH : FMT_STD;
  localparam int SW = PIX_W + GEN_SHIFT;

  // stores: factory and user sets; user offsets split by acquisition mode, [1] single line
  logic [PIX_W-1:0] fac_off_q [NPIX];
  logic [GAIN_W-1:0] fac_gain_q [NPIX];
  logic [PIX_W-1:0] usr_off_q [2][NPIX];
  logic [GAIN_W-1:0] usr_gain_q [NPIX];
  logic [SW-1:0] acc_q [NPIX];

  typedef enum logic [1:0] {GEN_IDLE, GEN_COLLECT, GEN_FINISH} gen_state_t;
  gen_state_t gen_q;
  logic [AW-1:0] pix_idx_q;
  logic [GEN_SHIFT:0] lines_q;
  logic [SW-1:0] max_q;
  logic active_q;
  logic reject_q;
  pix_beat_t out_q;

  function automatic logic [GAIN_W-1:0] clamp_gain(input logic [GAIN_W-1:0] g);
    return (g > GMAX) ? GMAX : g;
  endfunction

  // coefficient selection for the current pixel
  wire logic sel = active_q;
  wire logic [PIX_W-1:0] off_w = sel ? usr_off_q[single_line_mode][pix_idx_q]
                                     : fac_off_q[pix_idx_q];
  wire logic [GAIN_W-1:0] gain_w = clamp_gain(sel ? usr_gain_q[pix_idx_q]
                                                  : fac_gain_q[pix_idx_q]);
  wire logic do_off = (mode == CORR_OFFSET) || (mode == CORR_BOTH);
  wire logic do_gain = (mode == CORR_GAIN) || (mode == CORR_BOTH);
  // offset first, kept wide so saturation happens once at the end
  wire logic [PIX_W:0] sum_w = {1'b0, pix_in.data} + (do_off ? {1'b0, off_w} : '0);
  // product, scaled by the model's fraction width
  wire logic [PIX_W+GAIN_W:0] prod_w = sum_w * gain_w;
  wire logic [PIX_W+GAIN_W:0] scaled_w = prod_w >> FRAC;
  wire logic [PIX_W+GAIN_W:0] res_w = do_gain ? scaled_w
                                              : {{GAIN_W{1'b0}}, sum_w};
  // saturate; unsigned path cannot go under zero
  wire logic [PIX_W-1:0] sat_w = (res_w > PIX_MAX) ? PIX_MAX : res_w[PIX_W-1:0];
  wire logic gen_beat = (gen_q == GEN_COLLECT) && pix_in.valid;
  // include the current beat, else the maximum lags the stored averages by one line
  wire logic [SW-1:0] avg_w = (acc_q[pix_idx_q] + SW'(pix_in.data)) >> GEN_SHIFT;
  wire logic fmt_ok = (coef_fmt == MY_FMT);

  // output stage and pixel index
  always_ff @(posedge core_clk) begin
    if (reset) begin
      out_q <= '0;
      pix_idx_q <= '0;
    end else if (clk_en) begin
      out_q.valid <= pix_in.valid;
      out_q.last <= pix_in.last;
      if (pix_in.valid) begin
        out_q.data <= sat_w;
      end
      if (pix_in.valid) begin
        pix_idx_q <= pix_in.last ? '0 : pix_idx_q + 1'b1;
      end
    end
  end

  // generation sequencer: collect then compute per pixel
  always_ff @(posedge core_clk) begin
    if (reset) begin
      gen_q <= GEN_IDLE;
      lines_q <= '0;
      max_q <= '0;
    end else if (clk_en) begin
      unique case (gen_q)
        GEN_IDLE: if (gen_start) begin
          gen_q <= GEN_COLLECT;
          lines_q <= '0;
          max_q <= '0;
        end
        GEN_COLLECT: if (gen_beat && pix_in.last) begin
          lines_q <= lines_q + 1'b1;
          if (lines_q == (GEN_SHIFT+1)'(GEN_LINES - 1)) begin
            gen_q <= GEN_FINISH;
          end
        end
        GEN_FINISH: gen_q <= GEN_IDLE;
        default: gen_q <= GEN_IDLE;
      endcase
      if (gen_beat && lines_q == (GEN_SHIFT+1)'(GEN_LINES - 1) && avg_w > max_q) begin
        max_q <= avg_w;
      end
    end
  end

  // accumulators; cleared at start, summed during collection
  for (genvar i = 0; i < NPIX; i++) begin : g_acc
    always_ff @(posedge core_clk) begin
      if (clk_en) begin
        if (gen_q == GEN_IDLE && gen_start) begin
          acc_q[i] <= '0;
        end else if (gen_beat && pix_idx_q == AW'(i)) begin
          acc_q[i] <= acc_q[i] + SW'(pix_in.data);
        end
      end
    end
    // write offsets to the user area of the current mode
    always_ff @(posedge core_clk) begin
      if (clk_en && gen_q == GEN_FINISH) begin
        usr_off_q[single_line_mode][i] <= PIX_W'((max_q - (acc_q[i] >> GEN_SHIFT)));
      end
      if (clk_en && coef_we && fmt_ok && coef_addr == AW'(i)) begin
        usr_gain_q[i] <= coef_gain;
      end
    end
    // factory set: fixed content, no write path exists
    assign fac_off_q[i] = '0;
    assign fac_gain_q[i] = GAIN_W'(1 << FRAC);
  end

  // active set; factory at reset, user on generation finish, then use_user_set in idle
  always_ff @(posedge core_clk) begin
    if (reset) begin
      active_q <= 1'b0;
      reject_q <= 1'b0;
    end else if (clk_en) begin
      reject_q <= coef_we && !fmt_ok;
      if (gen_q == GEN_FINISH) begin
        active_q <= 1'b1;
      end else if (gen_q == GEN_IDLE) begin
        active_q <= use_user_set;
      end
    end
  end

  assign pix_out = out_q;
  assign user_active = active_q;
  assign gen_busy = (gen_q != GEN_IDLE);
  assign coef_reject = reject_q;

  pass_thru_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && pix_in.valid && mode == CORR_OFF |=> pix_out.data == $past(pix_in.data))
    else $error("pixel altered with correction off");
  sat_range_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && pix_in.valid && res_w > PIX_MAX |=> pix_out.data == PIX_MAX)
    else $error("result wrapped instead of saturating");
  // gain bound, judged on the corrected pixel
  gain_limit_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && pix_in.valid && mode == CORR_GAIN |=>
      ((PIX_W+GAIN_W+1)'(pix_out.data) << FRAC) <=
      (PIX_W+GAIN_W+1)'($past(pix_in.data)) * (PIX_W+GAIN_W+1)'(GMAX))
    else $error("gain above model limit");
  sequence gen_done_s;
    clk_en && gen_q == GEN_FINISH;
  endsequence
  user_activate_a: assert property (@(posedge core_clk) disable iff (reset)
    gen_done_s |=> user_active)
    else $error("user set not activated after generation");
  fmt_refuse_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && coef_we && coef_fmt != MY_FMT |=> coef_reject)
    else $error("foreign format accepted");
  gen_count_a: assert property (@(posedge core_clk) disable iff (reset)
    clk_en && gen_q == GEN_COLLECT && $past(gen_q) == GEN_IDLE |-> lines_q == '0)
    else $error("collection started with nonzero count");
  gain_only_a: assert property (@(posedge core_clk) disable iff (reset)
    mode == CORR_GAIN |-> sum_w == {1'b0, pix_in.data})
    else $error("offset applied in gain-only mode");
  fac_default_a: assert property (@(posedge core_clk)
    $past(reset) |-> !user_active) else $error("user set active after reset");
endmodule // line_shading_correction

/* File: verification/pixel_source.sv */
/*
  pixel_source: sensor side model that feeds one pixel beat per call.
  assumes the bench calls its tasks on core_clk falling edges.
*/
`timescale 1ns/10ps
module pixel_source
  import shading_pkg::*;
(
  input wire logic core_clk, // pixel clock
  output pix_beat_t beat     // stream towards the block
);
  initial beat = '0;

  // drive one beat; valid lines may follow back to back
  task automatic send(input logic [PIX_W-1:0] d, input logic l);
    @(negedge core_clk);
    beat <= '{valid: 1'b1, last: l, data: d};
  endtask

  // released bus shows inverted data so stale values never match
  task automatic stop();
    beat <= '{valid: 1'b0, last: 1'b0, data: ~beat.data};
  endtask
endmodule // pixel_source

/* File: verification/tb_top.sv */
/*
  tb_top: self-checking bench for line_shading_correction.
  assumes standard model, single pixel lines unless generating.
*/
`timescale 1ns/10ps
module tb_top;
  import shading_pkg::*;
  logic core_clk, reset, gen_start, coef_we, use_user_set;
  logic clk_en, single_line_mode;
  logic [5:0] coef_addr;
  logic [1:0] coef_fmt;
  logic [9:0] coef_gain;
  corr_mode_t mode;
  pix_beat_t pix_in, pix_out;
  logic user_active, gen_busy, coef_reject;
  int failures = 0, n_checks = 0, cyc = 0;

  pixel_source src (.core_clk(core_clk), .beat(pix_in));
  line_shading_correction DUT (.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
    .mode(mode), .single_line_mode(single_line_mode), .use_user_set(use_user_set),
    .gen_start(gen_start), .pix_in(pix_in), .coef_we(coef_we), .coef_fmt(coef_fmt),
    .coef_addr(coef_addr), .coef_gain(coef_gain), .pix_out(pix_out),
    .user_active(user_active), .gen_busy(gen_busy), .coef_reject(coef_reject));

  // 100 MHz clock and a hang guard well above the run length
  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      complete_run();
    end
  end

  task automatic chk(input logic [PIX_W-1:0] g, e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch at %0t: data %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch at %0t: flag %b expected %b", $time, g, e);
    end
  endtask

  // one single pixel line, result read one cycle later
  task automatic px(input logic [PIX_W-1:0] d, e);
    src.send(d, 1'b1);
    @(negedge core_clk);
    src.stop();
    chk1(pix_out.valid, 1'b1);
    chk1(pix_out.last, 1'b1);
    chk(pix_out.data, e);
  endtask

  // gain load for one pixel; wrong tag must be refused
  task automatic ld(input logic [5:0] a, input logic [9:0] g, input logic [1:0] f);
    @(negedge core_clk);
    coef_we <= 1'b1;
    coef_addr <= a;
    coef_gain <= g;
    coef_fmt <= f;
    @(negedge core_clk);
    coef_we <= 1'b0;
    chk1(coef_reject, f != FMT_STD);
  endtask

  // factory set, off, offset and gain modes leave the pixel unchanged
  task automatic t_factory();
    mode = CORR_OFF;
    px(12'h0_123, 12'h0_123);
    mode = CORR_OFFSET;
    px(12'h0_abc, 12'h0_abc);
    mode = CORR_GAIN;
    px(12'h0_fff, 12'h0_fff);
    chk1(user_active, 1'b0);
  endtask

  // user gain above 1.5 is clamped, product saturates, a refused load leaves it
  task automatic t_gain();
    // host refreshes user gains before they are applied
    ld(6'h00, 10'h3ff, FMT_STD);
    ld(6'h00, 10'h080, FMT_ENH);
    ld(6'h01, 10'h200, FMT_STD);
    use_user_set = 1'b1;
    repeat (2) @(negedge core_clk);
    chk1(user_active, 1'b1);
    px(12'h0_100, 12'h0_180);
    px(12'h0_c00, 12'h0_fff);
  endtask

  // 64 dark lines of two pixels in one acquisition mode; pixel 1 is the brightest
  task automatic gen_dark(input logic slm, input logic [PIX_W-1:0] dk);
    int i;
    single_line_mode = slm;
    mode = CORR_OFFSET;
    @(negedge core_clk);
    gen_start = 1'b1;
    @(negedge core_clk);
    gen_start = 1'b0;
    chk1(gen_busy, 1'b1);
    for (i = 0; i < 64; i++) begin
      if (i == 63) chk1(gen_busy, 1'b1);
      src.send(dk, 1'b0);
      src.send(12'h0_030, 1'b1);
    end
    @(negedge core_clk);
    src.stop();
    for (i = 0; i < 10 && gen_busy !== 1'b0; i++) @(negedge core_clk);
    chk1(gen_busy, 1'b0);
    chk1(user_active, 1'b1);
  endtask

  // other-mode offsets: pixel 0 lifted from 0x010 to 0x030
  task automatic t_gen();
    gen_dark(1'b0, 12'h0_010);
    px(12'h0_100, 12'h0_120);
    mode = CORR_BOTH;
    px(12'h0_100, 12'h0_1b0);
  endtask

  // single-line offsets land in their own area; the other area is kept
  task automatic t_single();
    gen_dark(1'b1, 12'h0_028);
    px(12'h0_100, 12'h0_108);
    single_line_mode = 1'b0;
    px(12'h0_100, 12'h0_120);
  endtask

  // clock enable low holds every register; the beat is taken once it rises
  task automatic t_freeze();
    mode = CORR_OFF;
    @(negedge core_clk);
    clk_en = 1'b0;
    src.send(12'h0_5a5, 1'b1);
    @(negedge core_clk);
    chk1(pix_out.valid, 1'b0);
    clk_en = 1'b1;
    @(negedge core_clk);
    src.stop();
    chk1(pix_out.valid, 1'b1);
    chk(pix_out.data, 12'h0_5a5);
  endtask

  // mid-run reset returns to idle and the factory set
  task automatic t_reset();
    @(negedge core_clk);
    reset = 1'b1;
    repeat (2) @(negedge core_clk);
    reset = 1'b0;
    chk1(user_active, 1'b0);
    chk1(gen_busy, 1'b0);
    chk1(pix_out.valid, 1'b0);
    mode = CORR_GAIN;
    use_user_set = 1'b0;
    px(12'h0_200, 12'h0_200);
  endtask

  task automatic complete_run();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    reset = 1;
    mode = CORR_OFF;
    use_user_set = 0;
    gen_start = 0;
    coef_we = 0;
    coef_fmt = FMT_STD;
    coef_gain = '0;
    coef_addr = '0;
    clk_en = 1;
    single_line_mode = 0;
    repeat (8) @(negedge core_clk);
    reset = 0;
    t_factory();
    t_gain();
    t_gen();
    t_single();
    t_freeze();
    t_reset();
    complete_run();
  end
endmodule // tb_top
